// ### rtl/rcpm_defs.vh
// Constants for the reset and column-strobe pin mode block
`ifndef RCPM_DEFS_VH
`define RCPM_DEFS_VH
`define RCPM_RESET_CLOCKS 7'h54
`define RCPM_CNT_W 7
`define RCPM_CNT_ONE 7'h01
`define RCPM_CNT_ZERO 7'h00
`define RCPM_MUX_W 3
`define RCPM_MUX_BUS_RESET 3'h4
`define RCPM_MUX_IDLE 3'h0
`define RCPM_PMC_W 8
`define RCPM_PMC_RESET 8'h00
`define RCPM_PORT_W 16
`define RCPM_PE_EN_HI 13
`define RCPM_PE_EN_LO 12
`define RCPM_ST_RESET 2'h0
`define RCPM_ST_COUNT 2'h1
`define RCPM_ST_RUN 2'h2
`endif

// ### rtl/rcpm_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module rcpm_sync
(
  input wire i_clock,
  input wire i_rst_n,
  input wire i_pin,
  output reg o_level
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  // Three flops, stages two and three agree
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        o_level <= s3_r;
    end
  end
endmodule // rcpm_sync
`default_nettype wire

// ### rtl/rcpm_edge.v
// Rising-edge detector with one-cycle pulse output
`timescale 1ns/100ps
`default_nettype none
module rcpm_edge
(
  input wire i_clock,
  input wire i_rst_n,
  input wire i_level,
  input wire i_enable,
  output reg o_rise
);
  reg prev_r;
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      prev_r <= 1'b0;
      o_rise <= 1'b0;
    end
    else
    begin
      prev_r <= i_level;
      o_rise <= i_enable & i_level & ~prev_r;
    end
  end
endmodule // rcpm_edge
`default_nettype wire

// ### rtl/rcpm_top.v
// Reset sequencing and column-strobe pin mode control
`timescale 1ns/100ps
`default_nettype none
`include "rcpm_defs.vh"
module rcpm_top
(
  input wire i_clock,
  input wire i_rst_n,
  input wire i_master_reset_in_n,
  input wire i_cpu_status_one_n,
  input wire i_strobe_mode_strap,
  input wire i_parity_error_in,
  input wire i_coproc_error_in,
  input wire [`RCPM_PORT_W-1:0] i_port_ctl,
  input wire i_mem_write,
  input wire i_powered_down,
  input wire i_powerdown_refresh_in,
  input wire i_refresh_req,
  input wire i_power_ctl_sample_strobe,
  input wire [`RCPM_PMC_W-1:0] i_power_mgmt_control,
  input wire i_col_strobe_high_3,
  input wire i_col_strobe_low_3,
  input wire i_col_strobe_low_2,
  output reg o_processor_reset_out,
  output reg o_dma_ack_enable,
  output reg [`RCPM_MUX_W-1:0] o_mux_control_field,
  output reg o_cpu_mode_32,
  output reg o_processor_busy_out,
  output reg o_strobe_input_mode,
  output reg o_col_strobe_high_3_oe,
  output reg o_col_strobe_low_3_oe,
  output reg o_col_strobe_low_2_oe,
  output reg o_parity_error_pulse,
  output reg o_irq13_pulse,
  output reg o_mem_dir,
  output reg o_refresh_out,
  output reg [`RCPM_PMC_W-1:0] o_power_mgmt_control,
  output reg o_seq_done
);
  wire mrst_lvl;
  wire status_lvl;
  wire strap_lvl;
  wire pe_lvl;
  wire coproc_error_in_lvl;
  wire powerdown_refresh_in_lvl;
  wire power_ctl_sample_strobe_lvl;
  wire pe_rise;
  wire coproc_error_in_rise;
  wire power_ctl_sample_strobe_rise;
  wire pe_enable;
  wire input_mode_nxt;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [`RCPM_CNT_W-1:0] cnt_r;
  reg [`RCPM_CNT_W-1:0] cnt_nxt;
  reg power_ctl_sample_strobe_prev_r;

  rcpm_sync u_sync_mrst
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_pin(i_master_reset_in_n),
    .o_level(mrst_lvl)
  );
  rcpm_sync u_sync_status
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_pin(i_cpu_status_one_n),
    .o_level(status_lvl)
  );
  rcpm_sync u_sync_strap
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_pin(i_strobe_mode_strap),
    .o_level(strap_lvl)
  );
  rcpm_sync u_sync_pe
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_pin(i_parity_error_in),
    .o_level(pe_lvl)
  );
  rcpm_sync u_sync_coproc_error_in
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_pin(i_coproc_error_in),
    .o_level(coproc_error_in_lvl)
  );
  rcpm_sync u_sync_powerdown_refresh_in
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_pin(i_powerdown_refresh_in),
    .o_level(powerdown_refresh_in_lvl)
  );
  rcpm_sync u_sync_power_ctl_sample_strobe
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_pin(i_power_ctl_sample_strobe),
    .o_level(power_ctl_sample_strobe_lvl)
  );

  // Parity input gated by mode and port bits
  assign pe_enable = o_strobe_input_mode & o_seq_done &
    i_port_ctl[`RCPM_PE_EN_HI] & i_port_ctl[`RCPM_PE_EN_LO];

  rcpm_edge u_edge_pe
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_level(pe_lvl),
    .i_enable(pe_enable),
    .o_rise(pe_rise)
  );
  rcpm_edge u_edge_coproc_error_in
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_level(coproc_error_in_lvl),
    .i_enable(o_strobe_input_mode & o_seq_done),
    .o_rise(coproc_error_in_rise)
  );

  assign power_ctl_sample_strobe_rise = power_ctl_sample_strobe_lvl & ~power_ctl_sample_strobe_prev_r;

  // Mode value after this edge
  assign input_mode_nxt = (state_r != `RCPM_ST_RUN) ? ~strap_lvl :
    o_strobe_input_mode;

  // Reset sequence state machine
  always @*
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      `RCPM_ST_RESET:
      begin
        cnt_nxt = `RCPM_CNT_ZERO;
        if (mrst_lvl)
          state_nxt = `RCPM_ST_COUNT;
      end
      `RCPM_ST_COUNT:
      begin
        cnt_nxt = cnt_r + `RCPM_CNT_ONE;
        if (cnt_r == `RCPM_RESET_CLOCKS - `RCPM_CNT_ONE)
          state_nxt = `RCPM_ST_RUN;
      end
      `RCPM_ST_RUN:
        cnt_nxt = `RCPM_CNT_ZERO;
      default:
        state_nxt = `RCPM_ST_RESET;
    endcase
    if (!mrst_lvl)
    begin
      state_nxt = `RCPM_ST_RESET;
      cnt_nxt = `RCPM_CNT_ZERO;
    end
  end

  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= `RCPM_ST_RESET;
      cnt_r <= `RCPM_CNT_ZERO;
      power_ctl_sample_strobe_prev_r <= 1'b0;
      o_processor_reset_out <= 1'b1;
      o_dma_ack_enable <= 1'b1;
      o_mux_control_field <= `RCPM_MUX_BUS_RESET;
      o_cpu_mode_32 <= 1'b0;
      o_processor_busy_out <= 1'b0;
      o_strobe_input_mode <= 1'b0;
      o_col_strobe_high_3_oe <= 1'b0;
      o_col_strobe_low_3_oe <= 1'b0;
      o_col_strobe_low_2_oe <= 1'b0;
      o_parity_error_pulse <= 1'b0;
      o_irq13_pulse <= 1'b0;
      o_mem_dir <= 1'b0;
      o_refresh_out <= 1'b0;
      o_power_mgmt_control <= `RCPM_PMC_RESET;
      o_seq_done <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      power_ctl_sample_strobe_prev_r <= power_ctl_sample_strobe_lvl;
      o_processor_reset_out <= (state_nxt != `RCPM_ST_RUN);
      o_dma_ack_enable <= (state_nxt != `RCPM_ST_RUN);
      o_mux_control_field <= (state_nxt != `RCPM_ST_RUN) ?
        `RCPM_MUX_BUS_RESET : `RCPM_MUX_IDLE;
      o_seq_done <= (state_nxt == `RCPM_ST_RUN);
      if (state_r != `RCPM_ST_RUN)
      begin
        o_cpu_mode_32 <= ~status_lvl;
        // Busy for self-test on newer core
        o_processor_busy_out <= ~status_lvl;
        o_strobe_input_mode <= ~strap_lvl;
      end
      o_col_strobe_high_3_oe <= (state_nxt == `RCPM_ST_RUN) & ~input_mode_nxt;
      o_col_strobe_low_3_oe <= (state_nxt == `RCPM_ST_RUN) & ~input_mode_nxt;
      o_col_strobe_low_2_oe <= (state_nxt == `RCPM_ST_RUN) & ~input_mode_nxt;
      o_parity_error_pulse <= pe_rise;
      o_irq13_pulse <= coproc_error_in_rise;
      o_mem_dir <= i_mem_write;
      o_refresh_out <= i_powered_down ? powerdown_refresh_in_lvl : i_refresh_req;
      if (power_ctl_sample_strobe_rise)
        o_power_mgmt_control <= i_power_mgmt_control;
    end
  end
endmodule // rcpm_top
`default_nettype wire

// ### testbench/rcpm_top_asserts.sv
// Checker for reset sequencing and strobe pin outputs
`timescale 1ns/100ps
`default_nettype none
module rcpm_chk (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_master_reset_in_n,
  input wire logic o_processor_reset_out,
  input wire logic o_dma_ack_enable,
  input wire logic [2:0] o_mux_control_field,
  input wire logic o_cpu_mode_32,
  input wire logic o_processor_busy_out,
  input wire logic o_strobe_input_mode,
  input wire logic o_col_strobe_low_2_oe,
  input wire logic o_parity_error_pulse,
  input wire logic o_irq13_pulse,
  input wire logic o_seq_done
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic [6:0] cnt_r;
  // Edges since the master reset pin went high
  always_ff @(posedge i_clock or negedge i_rst_n)
    if (!i_rst_n)
      cnt_r <= 7'h00;
    else
      cnt_r <= !i_master_reset_in_n ? 7'h00 : cnt_r + {6'h00, cnt_r != 7'h7F};
  hold_reset_a: assert property (
    cnt_r > 7'h07 && cnt_r < 7'h54 |-> o_processor_reset_out)
    else $error("reset released early");
  late_reset_a: assert property (
    cnt_r > 7'h5F |-> !o_processor_reset_out)
    else $error("reset held too long");
  master_hold_a: assert property (
    !i_master_reset_in_n |-> ##6 o_processor_reset_out)
    else $error("no reset while master low");
  bus_reset_a: assert property (
    o_dma_ack_enable == o_processor_reset_out && o_mux_control_field ==
    (o_processor_reset_out ? 3'h4 : 3'h0))
    else $error("bus reset code wrong");
  mode_keep_a: assert property (
    o_seq_done && $past(o_seq_done) |-> $stable(o_cpu_mode_32) &&
    o_processor_busy_out == o_cpu_mode_32)
    else $error("mode or busy changed");
  irq_gate_a: assert property (
    o_irq13_pulse |-> o_strobe_input_mode && o_seq_done ##1 !o_irq13_pulse)
    else $error("bad interrupt pulse");
  pe_gate_a: assert property (
    o_parity_error_pulse |-> o_strobe_input_mode ##1 !o_parity_error_pulse)
    else $error("bad parity pulse");
  oe_mode_a: assert property (
    o_col_strobe_low_2_oe |-> o_seq_done && !o_strobe_input_mode)
    else $error("strobe driven in input mode");
endmodule // rcpm_chk
bind rcpm_top rcpm_chk chk (.*);
`default_nettype wire

// ### testbench/rcpm_host.sv
// Board and processor model: master reset, status pin and strap
`timescale 1ns/100ps
`default_nettype none
module rcpm_host (
  input wire logic i_clock,
  input wire logic i_hold,
  input wire logic i_cpu32,
  input wire logic i_strap_low,
  input wire logic i_cpu_reset,
  output wire logic o_master_reset_n,
  output wire logic o_status_one_n,
  output wire logic o_strap
);
  logic tog_r = 1'h0;
  always @(posedge i_clock)
    tog_r <= !tog_r;
  assign o_master_reset_n = !i_hold;
  assign o_strap = !i_strap_low;
  // Status busy with bus cycles once out of reset
  assign o_status_one_n = i_cpu_reset ? !i_cpu32 : tog_r;
endmodule // rcpm_host
`default_nettype wire

// ### testbench/reset_and_cas_pin_mode_tb.sv
// Self-checking bench for reset sequencing and strobe pin modes
`timescale 1ns/100ps
`default_nettype none
module reset_and_cas_pin_mode_tb;
  logic i_clock = 1'h0, i_rst_n = 1'h0, hold = 1'h1, cpu32 = 1'h0, low = 1'h0;
  logic i_parity_error_in = 1'h0, i_coproc_error_in = 1'h0, i_mem_write = 1'h0;
  logic i_powered_down = 1'h0, i_powerdown_refresh_in = 1'h0;
  logic i_refresh_req = 1'h0, i_power_ctl_sample_strobe = 1'h0;
  logic [15:0] i_port_ctl = 16'h0000;
  logic [7:0] i_power_mgmt_control = 8'h00, exp_pmc;
  wire i_master_reset_in_n, i_cpu_status_one_n, i_strobe_mode_strap;
  wire i_col_strobe_high_3 = i_strobe_mode_strap;
  wire i_col_strobe_low_3 = i_parity_error_in;
  wire i_col_strobe_low_2 = i_coproc_error_in;
  wire o_processor_reset_out, o_dma_ack_enable, o_cpu_mode_32;
  wire o_processor_busy_out, o_strobe_input_mode, o_col_strobe_high_3_oe;
  wire o_col_strobe_low_3_oe, o_col_strobe_low_2_oe, o_parity_error_pulse;
  wire o_irq13_pulse, o_mem_dir, o_refresh_out, o_seq_done;
  wire [2:0] o_mux_control_field;
  wire [7:0] o_power_mgmt_control;
  int err_count = 0, checked = 0, n, k, npe, nirq;
  always #10 i_clock = ~i_clock;
  rcpm_top uut (.*);
  rcpm_host host (.i_clock(i_clock), .i_hold(hold), .i_cpu32(cpu32),
    .i_strap_low(low), .i_cpu_reset(o_processor_reset_out),
    .o_master_reset_n(i_master_reset_in_n),
    .o_status_one_n(i_cpu_status_one_n), .o_strap(i_strobe_mode_strap));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run(input int c);
    repeat (c)
    begin
      @(posedge i_clock);
      #1;
      npe += o_parity_error_pulse;
      nirq += o_irq13_pulse;
    end
  endtask
  task automatic results;
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    void'($urandom(67));
    run(3);
    i_rst_n = 1'h1;
    for (int i = 0; i < 4; i++)
    begin
      hold = 1'h1;
      cpu32 = i[0];
      low = i[1];
      i_port_ctl = {2'($urandom), 1'h1, i[0], 12'($urandom)};
      run(10);
      chk({o_processor_reset_out, o_dma_ack_enable, o_mux_control_field},
        5'h1C);
      hold = 1'h0;
      n = 0;
      while (o_processor_reset_out !== 1'h0 && n < 200)
      begin
        run(1);
        n++;
      end
      chk(n >= 86 && n <= 95, 1);
      if (n == 200)
        results();
      chk({o_dma_ack_enable, o_mux_control_field}, 4'h0);
      run(4);
      chk({o_cpu_mode_32, o_processor_busy_out}, {2{cpu32}});
      chk({o_strobe_input_mode, o_col_strobe_low_2_oe, o_col_strobe_low_3_oe,
        o_col_strobe_high_3_oe}, {low, {3{!low}}});
      npe = 0;
      nirq = 0;
      k = $urandom_range(3, 1);
      repeat (k)
      begin
        {i_parity_error_in, i_coproc_error_in} = 2'h3;
        run(8);
        {i_parity_error_in, i_coproc_error_in} = 2'h0;
        run(8);
      end
      i_parity_error_in = 1'h1;
      run(20);
      i_parity_error_in = 1'h0;
      run(8);
      chk(npe, (low && i[0]) ? k + 1 : 0);
      chk(nirq, low ? k : 0);
    end
    repeat (24)
    begin
      {i_mem_write, i_powered_down, i_powerdown_refresh_in, i_refresh_req,
        i_power_mgmt_control} = 12'($urandom);
      run(1);
      chk(o_mem_dir, i_mem_write);
      i_power_ctl_sample_strobe = 1'h1;
      exp_pmc = i_power_mgmt_control;
      run(8);
      chk(o_refresh_out, i_powered_down ? i_powerdown_refresh_in
        : i_refresh_req);
      chk(o_power_mgmt_control, exp_pmc);
      i_power_ctl_sample_strobe = 1'h0;
      run(2);
    end
    results();
  end
endmodule // reset_and_cas_pin_mode_tb
`default_nettype wire
